/* rtl/rnm_pkg.sv */
package rnm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_MACHINE_STATE = 8'h00;
   localparam logic [7:0] OFS_SAVE_RESTORE_PC = 8'h04;
   localparam logic [7:0] OFS_SAVE_RESTORE_STATE = 8'h08;
   localparam logic [7:0] OFS_DATA_FAULT_STATUS = 8'h0C;
   localparam logic [7:0] OFS_DATA_FAULT_ADDRESS = 8'h10;
   localparam logic [7:0] OFS_FP_EXCEPTION_CAUSE = 8'h14;
   localparam logic [7:0] OFS_FETCH_DEBUG_CONTROL = 8'h18;
   localparam logic [7:0] OFS_LOADSTORE_DEBUG_A = 8'h1C;
   localparam logic [7:0] OFS_LOADSTORE_DEBUG_B = 8'h20;
   localparam logic [7:0] OFS_DEBUG_COUNTER_A = 8'h24;
   localparam logic [7:0] OFS_DEBUG_COUNTER_B = 8'h28;
   localparam logic [7:0] OFS_BURST_BUFFER_CFG = 8'h2C;
   localparam logic [7:0] OFS_DEBUG_ENABLE = 8'h30;
   localparam logic [7:0] OFS_BLOCK_STATUS = 8'h34;

   // machine_state fields, as vector index (msb = bit 0 of the core)
   localparam int MS_WIDE = 31;
   localparam int MS_ILE = 16;
   localparam int MS_ME = 12;
   localparam int MS_FPA = 11;
   localparam int MS_FPB = 8;
   localparam int MS_PREFIX = 6;
   localparam int MS_DECOMPRESSION_ENABLE = 2;
   localparam int MS_RI = 1;
   localparam int MS_LE = 0;

   // save_restore_state layout
   localparam logic [31:0] SRS_COPY_MASK = 32'h87C0_FFFF;
   localparam int SRS_FETCH = 30;

   // small control fields
   localparam int BB_EN_COMP = 0;
   localparam int BB_COMPRESSION_ON_EXCEPTION = 1;
   localparam int DE_CHECKSTOP_DEBUG_ENABLE = 0;
   localparam int DE_MACHINE_CHECK_DEBUG_ENABLE = 1;
   localparam int ST_CHECKSTOP_BIT = 0;
   localparam int ST_DEBUG_EN_BIT = 1;
   localparam int ST_FP_PRECISE_BIT = 2;
   localparam int ST_NMI_PEND_BIT = 3;

   // reset values and vectors
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [15:0] RST_ZERO_HALF = 16'h0000;
   localparam logic [31:0] VEC_BASE_HIGH = 32'hFFF0_0000;
   localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
   localparam logic [31:0] VEC_RESET_OFS = 32'h0000_0100;
   localparam logic [31:0] VEC_MCHECK_OFS = 32'h0000_0200;

   typedef enum logic [1:0] {
      EXC_NONE,
      EXC_RESET,
      EXC_NMI,
      EXC_MCHECK
   } rnm_exc_e;

   typedef enum {ST_RUN, ST_STOPPED} rnm_state_e;

   // machine-check request from the core datapath
   typedef struct packed {
      logic        req;
      logic        fetch;
      logic        data;
      logic        xform;
      logic [31:0] fault_pc;
      logic [31:0] addr;
      logic [31:0] instr;
   } rnm_mcheck_s;

   typedef struct packed {
      logic        take;
      rnm_exc_e    kind;
      logic [31:0] vector;
   } rnm_entry_s;
endpackage : rnm_pkg

/* rtl/rnm_exception_unit.sv */
module rnm_exception_unit (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [31:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_power_on_reset_in_n,
   input wire logic i_hard_reset_in_n,
   input wire logic i_soft_reset_in_n,
   input wire logic i_nonmaskable_irq_line_n,
   input wire logic i_internal_reset_req,
   input wire logic i_reset_cfg_prefix,
   input wire logic i_debug_mode_strap,
   input wire logic [31:0] i_next_pc,
   input wire rnm_pkg::rnm_mcheck_s i_mcheck,
   output rnm_pkg::rnm_entry_s o_entry,
   output logic o_checkstop,
   output logic o_checkstop_ind,
   output logic o_debug_entry,
   output logic o_fp_precise
);
   import rnm_pkg::*;

   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [3:0] sync3_r;
   logic [3:0] pin_r;
   logic boot_r;
   logic debug_en_r;
   logic nmi_pin_d_r;
   logic nmi_pend_r;
   rnm_state_e state_r;
   logic [31:0] machine_state_r;
   logic [31:0] save_restore_pc_r;
   logic [31:0] save_restore_state_r;
   logic [31:0] data_fault_status_r;
   logic [31:0] data_fault_address_r;
   logic [31:0] fp_exception_cause_r;
   logic [31:0] fetch_debug_control_r;
   logic [31:0] loadstore_debug_control_a_r;
   logic [31:0] loadstore_debug_control_b_r;
   logic [31:0] debug_counter_a_r;
   logic [31:0] debug_counter_b_r;
   logic [1:0] burst_buffer_module_config_r;
   logic [1:0] debug_enable_reg_r;
   rnm_entry_s entry_r;
   logic checkstop_ind_r;
   logic debug_entry_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   logic reset_act;
   logic nmi_take;
   logic mc_take;
   logic mc_handler;
   logic mc_stop;
   logic mc_debug;
   logic dcmp_val;
   logic wr;
   logic rd;
   logic hit;
   logic [7:0] ofs;
   logic [31:0] ms_exc;
   logic [31:0] dfs_nxt;
   logic [31:0] rd_mux;

   // pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_r <= 4'hF;
         sync2_r <= 4'hF;
         sync3_r <= 4'hF;
      end else begin
         sync1_r <= {i_nonmaskable_irq_line_n, i_soft_reset_in_n,
                     i_hard_reset_in_n, i_power_on_reset_in_n};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   generate
      for (genvar g = 0; g < 4; g++) begin : g_pin
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               pin_r[g] <= 1'b1;
            end else if (sync2_r[g] == sync3_r[g]) begin
               pin_r[g] <= sync3_r[g];
            end
         end
      end
   endgenerate

   // exception selection
   assign reset_act = !pin_r[0] || !pin_r[1] || !pin_r[2]
                      || i_internal_reset_req;
   assign dcmp_val = burst_buffer_module_config_r[BB_EN_COMP]
                     & burst_buffer_module_config_r[BB_COMPRESSION_ON_EXCEPTION];
   assign mc_take = i_mcheck.req && !reset_act
                    && state_r == ST_RUN;
   assign nmi_take = nmi_pend_r && !reset_act && !mc_take
                     && state_r == ST_RUN;

   always_comb begin
      mc_handler = 1'b0;
      mc_stop = 1'b0;
      mc_debug = 1'b0;
      if (!debug_en_r) begin
         mc_handler = machine_state_r[MS_ME];
         mc_stop = !machine_state_r[MS_ME];
      end else if (machine_state_r[MS_ME]) begin
         mc_debug = debug_enable_reg_r[DE_MACHINE_CHECK_DEBUG_ENABLE];
         mc_handler = !debug_enable_reg_r[DE_MACHINE_CHECK_DEBUG_ENABLE];
      end else begin
         mc_debug = debug_enable_reg_r[DE_CHECKSTOP_DEBUG_ENABLE];
         mc_stop = !debug_enable_reg_r[DE_CHECKSTOP_DEBUG_ENABLE];
      end
   end

   // machine_state image after nmi or machine check entry
   always_comb begin
      ms_exc = RST_ZERO;
      ms_exc[MS_PREFIX] = machine_state_r[MS_PREFIX];
      ms_exc[MS_ME] = machine_state_r[MS_ME];
      ms_exc[MS_LE] = machine_state_r[MS_ILE];
      ms_exc[MS_DECOMPRESSION_ENABLE] = dcmp_val;
   end

   // data fault status from the faulting instruction
   always_comb begin
      dfs_nxt = RST_ZERO;
      if (i_mcheck.xform) begin
         dfs_nxt[16:15] = i_mcheck.instr[2:1];
         dfs_nxt[14] = i_mcheck.instr[6];
         dfs_nxt[13:10] = i_mcheck.instr[10:7];
      end else begin
         dfs_nxt[14] = i_mcheck.instr[26];
         dfs_nxt[13:10] = i_mcheck.instr[30:27];
      end
      dfs_nxt[9:0] = i_mcheck.instr[25:16];
   end

   // apb decode
   assign ofs = i_paddr[7:0];
   assign wr = i_psel && i_penable && i_pwrite && hit;
   assign rd = i_psel && i_penable && !i_pwrite;

   always_comb begin
      hit = (i_paddr[31:8] == 24'h00_0000) && (ofs[1:0] == 2'b00)
            && (ofs <= OFS_BLOCK_STATUS);
      rd_mux = RST_ZERO;
      case (ofs)
         OFS_MACHINE_STATE: rd_mux = machine_state_r;
         OFS_SAVE_RESTORE_PC: rd_mux = save_restore_pc_r;
         OFS_SAVE_RESTORE_STATE: rd_mux = save_restore_state_r;
         OFS_DATA_FAULT_STATUS: rd_mux = data_fault_status_r;
         OFS_DATA_FAULT_ADDRESS: rd_mux = data_fault_address_r;
         OFS_FP_EXCEPTION_CAUSE: rd_mux = fp_exception_cause_r;
         OFS_FETCH_DEBUG_CONTROL: rd_mux = fetch_debug_control_r;
         OFS_LOADSTORE_DEBUG_A: rd_mux = loadstore_debug_control_a_r;
         OFS_LOADSTORE_DEBUG_B: rd_mux = loadstore_debug_control_b_r;
         OFS_DEBUG_COUNTER_A: rd_mux = debug_counter_a_r;
         OFS_DEBUG_COUNTER_B: rd_mux = debug_counter_b_r;
         OFS_BURST_BUFFER_CFG: rd_mux[1:0] = burst_buffer_module_config_r;
         OFS_DEBUG_ENABLE: rd_mux[1:0] = debug_enable_reg_r;
         OFS_BLOCK_STATUS: begin
            rd_mux[ST_CHECKSTOP_BIT] = (state_r == ST_STOPPED);
            rd_mux[ST_DEBUG_EN_BIT] = debug_en_r;
            rd_mux[ST_FP_PRECISE_BIT] = o_fp_precise;
            rd_mux[ST_NMI_PEND_BIT] = nmi_pend_r;
         end
         default: rd_mux = RST_ZERO;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prdata_r <= RST_ZERO;
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= 1'b0;
         if (i_psel && !i_penable) begin
            prdata_r <= hit ? rd_mux : RST_ZERO;
            pslverr_r <= !hit;
         end else if (rd) begin
            prdata_r <= RST_ZERO;
         end
      end
   end

   // strap capture and boot marker
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         boot_r <= 1'b0;
         debug_en_r <= 1'b0;
      end else if (!boot_r) begin
         boot_r <= 1'b1;
         debug_en_r <= i_debug_mode_strap;
      end
   end

   // nmi request on the assertion edge; set wins over clear
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         nmi_pin_d_r <= 1'b1;
         nmi_pend_r <= 1'b0;
      end else begin
         nmi_pin_d_r <= pin_r[3];
         if (nmi_pin_d_r && !pin_r[3]) begin
            nmi_pend_r <= 1'b1;
         end else if (nmi_take || reset_act) begin
            nmi_pend_r <= 1'b0;
         end
      end
   end

   // run / checkstop state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= ST_RUN;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (mc_take && mc_stop) begin
                  state_r <= ST_STOPPED;
               end
            end
            ST_STOPPED: begin
               if (reset_act) begin
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // machine_state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         machine_state_r <= RST_ZERO;
      end else if (!boot_r || reset_act) begin
         machine_state_r <= RST_ZERO;
         machine_state_r[MS_ME] <= machine_state_r[MS_ME];
         machine_state_r[MS_DECOMPRESSION_ENABLE] <= dcmp_val;
         machine_state_r[MS_PREFIX] <= i_reset_cfg_prefix;
      end else if (nmi_take || (mc_take && mc_handler)) begin
         machine_state_r <= ms_exc;
      end else if (wr && ofs == OFS_MACHINE_STATE) begin
         machine_state_r <= i_pwdata;
         machine_state_r[MS_WIDE] <= 1'b0;
      end
   end

   assign o_fp_precise = machine_state_r[MS_FPA]
                         | machine_state_r[MS_FPB];

   // save/restore registers; left as they were on pin and internal resets
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         save_restore_pc_r <= RST_ZERO;
         save_restore_state_r <= RST_ZERO;
      end else if (nmi_take) begin
         save_restore_pc_r <= i_next_pc;
         save_restore_state_r <= machine_state_r & SRS_COPY_MASK;
      end else if (mc_take && mc_handler) begin
         save_restore_pc_r <= i_mcheck.fault_pc;
         save_restore_state_r <= machine_state_r & SRS_COPY_MASK;
         save_restore_state_r[SRS_FETCH] <= i_mcheck.fetch;
      end else if (wr) begin
         if (ofs == OFS_SAVE_RESTORE_PC) begin
            save_restore_pc_r <= i_pwdata;
         end
         if (ofs == OFS_SAVE_RESTORE_STATE) begin
            save_restore_state_r <= i_pwdata;
         end
      end
   end

   // fault status and address, data machine checks only
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         data_fault_status_r <= RST_ZERO;
         data_fault_address_r <= RST_ZERO;
      end else if (mc_take && mc_handler && i_mcheck.data) begin
         data_fault_status_r <= dfs_nxt;
         data_fault_address_r <= i_mcheck.addr;
      end else if (wr) begin
         if (ofs == OFS_DATA_FAULT_STATUS) begin
            data_fault_status_r <= i_pwdata;
         end
         if (ofs == OFS_DATA_FAULT_ADDRESS) begin
            data_fault_address_r <= i_pwdata;
         end
      end
   end

   // debug and fp cause registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fp_exception_cause_r <= RST_ZERO;
         fetch_debug_control_r <= RST_ZERO;
         loadstore_debug_control_a_r <= RST_ZERO;
         loadstore_debug_control_b_r <= RST_ZERO;
         debug_counter_a_r <= RST_ZERO;
         debug_counter_b_r <= RST_ZERO;
      end else if (reset_act) begin
         fp_exception_cause_r <= RST_ZERO;
         fetch_debug_control_r <= RST_ZERO;
         loadstore_debug_control_a_r <= RST_ZERO;
         loadstore_debug_control_b_r <= RST_ZERO;
         debug_counter_a_r[15:0] <= RST_ZERO_HALF;
         debug_counter_b_r[15:0] <= RST_ZERO_HALF;
      end else if (wr) begin
         case (ofs)
            OFS_FP_EXCEPTION_CAUSE: fp_exception_cause_r <= i_pwdata;
            OFS_FETCH_DEBUG_CONTROL: fetch_debug_control_r <= i_pwdata;
            OFS_LOADSTORE_DEBUG_A: loadstore_debug_control_a_r <= i_pwdata;
            OFS_LOADSTORE_DEBUG_B: loadstore_debug_control_b_r <= i_pwdata;
            OFS_DEBUG_COUNTER_A: debug_counter_a_r <= i_pwdata;
            OFS_DEBUG_COUNTER_B: debug_counter_b_r <= i_pwdata;
            default: ;
         endcase
      end
   end

   // compression and debug enable controls
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         burst_buffer_module_config_r <= 2'b00;
         debug_enable_reg_r <= 2'b00;
      end else if (wr) begin
         if (ofs == OFS_BURST_BUFFER_CFG) begin
            burst_buffer_module_config_r <= i_pwdata[1:0];
         end
         if (ofs == OFS_DEBUG_ENABLE) begin
            debug_enable_reg_r <= i_pwdata[1:0];
         end
      end
   end

   // entry record, checkstop indication and debug entry
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         entry_r <= '0;
         checkstop_ind_r <= 1'b0;
         debug_entry_r <= 1'b0;
      end else begin
         entry_r.take <= 1'b0;
         checkstop_ind_r <= mc_take && mc_stop;
         debug_entry_r <= mc_take && mc_debug;
         if (reset_act || nmi_take) begin
            entry_r.take <= 1'b1;
            entry_r.kind <= reset_act ? EXC_RESET : EXC_NMI;
            entry_r.vector <= (i_reset_cfg_prefix ? VEC_BASE_HIGH
                               : VEC_BASE_LOW) | VEC_RESET_OFS;
         end else if (mc_take && mc_handler) begin
            entry_r.take <= 1'b1;
            entry_r.kind <= EXC_MCHECK;
            entry_r.vector <= (machine_state_r[MS_PREFIX] ? VEC_BASE_HIGH
                               : VEC_BASE_LOW) | VEC_MCHECK_OFS;
         end
      end
   end

   assign o_entry = entry_r;
   assign o_checkstop = (state_r == ST_STOPPED);
   assign o_checkstop_ind = checkstop_ind_r;
   assign o_debug_entry = debug_entry_r;
   assign o_prdata = prdata_r;
   assign o_pready = 1'b1;
   assign o_pslverr = pslverr_r && i_psel && i_penable;
endmodule : rnm_exception_unit

/* tb/rnm_exception_checker.sv */
module rnm_exception_checker (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_power_on_reset_in_n,
   input wire logic i_hard_reset_in_n,
   input wire logic i_soft_reset_in_n,
   input wire logic i_internal_reset_req,
   input wire logic i_reset_cfg_prefix,
   input wire rnm_pkg::rnm_mcheck_s i_mcheck,
   input wire rnm_pkg::rnm_entry_s o_entry,
   input wire logic o_checkstop,
   input wire logic o_checkstop_ind,
   input wire logic o_debug_entry,
   input wire logic o_fp_precise
);
   timeunit 1ns;
   timeprecision 1ps;
   import rnm_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence pins_quiet;
      (i_power_on_reset_in_n && i_hard_reset_in_n && i_soft_reset_in_n
         && !i_internal_reset_req)[*8];
   endsequence
   sequence mc_handled;
      (o_entry.take && o_entry.kind == EXC_MCHECK) || o_checkstop_ind
         || o_debug_entry;
   endsequence
   a_int_reset: assert property (
      i_internal_reset_req |=> o_entry.take && o_entry.kind == EXC_RESET)
      else $error("reset request not taken");
   a_mc_action: assert property (
      pins_quiet ##0 (i_mcheck.req && !o_checkstop) |=> mc_handled)
      else $error("machine check without action");
   a_stop_hold: assert property (
      pins_quiet ##0 o_checkstop |=> o_checkstop)
      else $error("checkstop left without reset");
   a_stop_quiet: assert property (
      o_checkstop |-> !o_entry.take && !o_debug_entry)
      else $error("activity during checkstop");
   a_stop_ind: assert property (
      o_checkstop_ind |-> o_checkstop ##1 !o_checkstop_ind)
      else $error("bad checkstop indication");
   a_vec_boot: assert property (
      o_entry.take && o_entry.kind != EXC_MCHECK |-> o_entry.vector ==
      ($past(i_reset_cfg_prefix) ? 32'hFFF0_0100 : 32'h0000_0100))
      else $error("wrong reset or nmi vector");
   a_vec_mcheck: assert property (
      o_entry.take && o_entry.kind == EXC_MCHECK |->
      o_entry.vector inside {32'hFFF0_0200, 32'h0000_0200})
      else $error("wrong machine check vector");
   a_fp_reset: assert property (
      o_entry.take && o_entry.kind == EXC_RESET |-> !o_fp_precise)
      else $error("fp mode survives reset");
endmodule : rnm_exception_checker

/* tb/rnm_siu_model.sv */
module rnm_siu_model #(
   parameter int AUTO_DLY = 16
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_rst_go,
   input wire logic [1:0] i_rst_sel,
   input wire logic i_nmi_go,
   input wire logic i_checkstop_ind,
   output logic o_power_on_reset_in_n,
   output logic o_hard_reset_in_n,
   output logic o_soft_reset_in_n,
   output logic o_nonmaskable_irq_line_n,
   output logic o_internal_reset_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pin_cnt_r;
   logic [1:0] sel_r;
   logic [3:0] nmi_cnt_r;
   logic [4:0] auto_cnt_r;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_cnt_r <= 4'h0;
         sel_r <= 2'h0;
      end else if (i_rst_go) begin
         pin_cnt_r <= 4'h6;
         sel_r <= i_rst_sel;
      end else if (pin_cnt_r != 4'h0) begin
         pin_cnt_r <= pin_cnt_r - 4'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         nmi_cnt_r <= 4'h0;
      end else if (i_nmi_go) begin
         nmi_cnt_r <= 4'h8;
      end else if (nmi_cnt_r != 4'h0) begin
         nmi_cnt_r <= nmi_cnt_r - 4'h1;
      end
   end
   // automatic reset after a checkstop indication
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         auto_cnt_r <= 5'h00;
      end else if (i_checkstop_ind) begin
         auto_cnt_r <= 5'(AUTO_DLY);
      end else if (auto_cnt_r != 5'h00) begin
         auto_cnt_r <= auto_cnt_r - 5'h01;
      end
   end
   assign o_power_on_reset_in_n = !(pin_cnt_r != 4'h0 && sel_r == 2'h1);
   assign o_hard_reset_in_n = !(pin_cnt_r != 4'h0 && sel_r == 2'h2);
   assign o_soft_reset_in_n = !(pin_cnt_r != 4'h0 && sel_r == 2'h3);
   assign o_nonmaskable_irq_line_n = (nmi_cnt_r == 4'h0);
   assign o_internal_reset_req = (pin_cnt_r != 4'h0 && sel_r == 2'h0)
      || auto_cnt_r == 5'h01;
endmodule : rnm_siu_model

/* tb/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rnm_pkg::*;
   localparam logic [5:0] ROWS [6] = '{6'h0C, 6'h11, 6'h24, 6'h2A, 6'h39,
      6'h36};
   localparam logic [2:0] MC_CASE [3] = '{3'h3, 3'h2, 3'h4};
   logic i_clk = 1'b0;
   logic i_reset_n, psel, penable, pwrite, strap, prefix, rst_go, nmi_go;
   logic pready, pslverr, por_n, hrd_n, sft_n, nmi_n, int_req, err;
   logic stop, stop_ind, dbg, fpp;
   logic [31:0] paddr, pwdata, prdata, next_pc, q, dfs, dfa;
   logic [31:0] v_k [4];
   logic [1:0] rst_sel;
   rnm_mcheck_s mc;
   rnm_entry_s ent;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   int n_k [4];
   int n_stop, n_dbg, i, r;
   always #20 i_clk = ~i_clk;
   rnm_exception_unit u_rnm_exception_unit (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_paddr(paddr), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_power_on_reset_in_n(por_n), .i_hard_reset_in_n(hrd_n),
      .i_soft_reset_in_n(sft_n), .i_nonmaskable_irq_line_n(nmi_n),
      .i_internal_reset_req(int_req), .i_reset_cfg_prefix(prefix),
      .i_debug_mode_strap(strap), .i_next_pc(next_pc), .i_mcheck(mc),
      .o_entry(ent), .o_checkstop(stop), .o_checkstop_ind(stop_ind),
      .o_debug_entry(dbg), .o_fp_precise(fpp));
   rnm_siu_model u_rnm_siu_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_rst_go(rst_go), .i_rst_sel(rst_sel), .i_nmi_go(nmi_go),
      .i_checkstop_ind(stop_ind), .o_power_on_reset_in_n(por_n),
      .o_hard_reset_in_n(hrd_n), .o_soft_reset_in_n(sft_n),
      .o_nonmaskable_irq_line_n(nmi_n), .o_internal_reset_req(int_req));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h00_0000, a};
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1) @(posedge i_clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask : rdc
   task automatic watch(input int n);
      n_k = '{0, 0, 0, 0};
      n_stop = 0;
      n_dbg = 0;
      repeat (n) begin
         @(posedge i_clk);
         if (ent.take === 1'b1) begin
            n_k[ent.kind]++;
            v_k[ent.kind] = ent.vector;
         end
         if (stop_ind === 1'b1) n_stop++;
         if (dbg === 1'b1) n_dbg++;
      end
   endtask : watch
   task automatic mchk(input logic f, input logic d, input logic x);
      @(posedge i_clk);
      mc.req <= 1'b1;
      mc.fetch <= f;
      mc.data <= d;
      mc.xform <= x;
      @(posedge i_clk);
      mc.req <= 1'b0;
   endtask : mchk
   task automatic pulse(input logic nmi, input logic [1:0] sel);
      @(posedge i_clk);
      nmi_go <= nmi;
      rst_go <= !nmi;
      rst_sel <= sel;
      @(posedge i_clk);
      nmi_go <= 1'b0;
      rst_go <= 1'b0;
   endtask : pulse
   task automatic hw_reset(input logic s);
      @(posedge i_clk);
      strap <= s;
      i_reset_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
   endtask : hw_reset
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("unexpected at %0t: timeout", $time);
         complete_run();
      end
   end
   initial begin
      {psel, penable, pwrite, strap, rst_go, nmi_go, i_reset_n} = 7'h00;
      {paddr, pwdata, next_pc, rst_sel} = '0;
      mc = '0;
      prefix = 1'b1;
      hw_reset(1'b0);
      rdc(OFS_MACHINE_STATE, 32'h0000_0040);
      apb(1'b0, 8'h38, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      apb(1'b1, OFS_MACHINE_STATE, 32'hFFFF_FFFF);
      rdc(OFS_MACHINE_STATE, 32'h7FFF_FFFF);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, OFS_MACHINE_STATE, {20'h0_0000, i[1], 2'h0, i[0], 8'h00});
         @(posedge i_clk);
         chk(32'(fpp), 32'(i != 0));
      end
      for (i = 0; i < 6; i++)
         apb(1'b1, OFS_FP_EXCEPTION_CAUSE + 8'(4 * i), 32'hFFFF_FFFF);
      apb(1'b1, OFS_BURST_BUFFER_CFG, 32'h0000_0003);
      apb(1'b1, OFS_MACHINE_STATE, 32'h0000_1000);
      for (i = 0; i < 4; i++) begin
         prefix <= i[0];
         pulse(1'b0, 2'(i));
         watch(20);
         chk(32'(n_k[EXC_RESET] > 0), 32'h0000_0001);
         chk(v_k[EXC_RESET], i[0] ? 32'hFFF0_0100 : 32'h0000_0100);
      end
      for (i = 0; i < 4; i++)
         rdc(OFS_FP_EXCEPTION_CAUSE + 8'(4 * i), 32'h0000_0000);
      rdc(OFS_DEBUG_COUNTER_A, 32'hFFFF_0000);
      rdc(OFS_DEBUG_COUNTER_B, 32'hFFFF_0000);
      rdc(OFS_MACHINE_STATE, 32'h0000_1044);
      prefix <= 1'b0;
      next_pc <= 32'h1234_5678;
      apb(1'b1, OFS_MACHINE_STATE, 32'h7FFF_7FFF);
      pulse(1'b1, 2'h0);
      watch(20);
      chk(32'(n_k[EXC_NMI]), 32'h0000_0001);
      chk(v_k[EXC_NMI], 32'h0000_0100);
      rdc(OFS_SAVE_RESTORE_PC, 32'h1234_5678);
      rdc(OFS_SAVE_RESTORE_STATE, 32'h07C0_7FFF);
      rdc(OFS_MACHINE_STATE, 32'h0000_1045);
      for (i = 0; i < 3; i++) begin
         apb(1'b1, OFS_MACHINE_STATE, 32'h7FFF_7FFF);
         mc.fault_pc <= 32'h0000_4000 + 32'(i);
         mc.addr <= 32'hA000_0010 + 32'(i);
         mc.instr <= 32'h0000_0006;
         mchk(MC_CASE[i][2], MC_CASE[i][1], MC_CASE[i][0]);
         watch(6);
         chk(32'(n_k[EXC_MCHECK]), 32'h0000_0001);
         chk(v_k[EXC_MCHECK], 32'hFFF0_0200);
         rdc(OFS_SAVE_RESTORE_PC, 32'h0000_4000 + 32'(i));
         rdc(OFS_SAVE_RESTORE_STATE,
            {1'b0, MC_CASE[i][2], 30'h07C0_7FFF});
         if (MC_CASE[i][1]) begin
            dfs = MC_CASE[i][0] ? 32'h0001_8000 : 32'h0000_0000;
            dfa = 32'hA000_0010 + 32'(i);
         end
         apb(1'b0, OFS_DATA_FAULT_STATUS, 32'h0000_0000);
         chk(q & 32'hFFFF_8000, dfs);
         rdc(OFS_DATA_FAULT_ADDRESS, dfa);
         rdc(OFS_MACHINE_STATE, 32'h0000_1045);
      end
      apb(1'b1, OFS_BURST_BUFFER_CFG, 32'h0000_0001);
      pulse(1'b0, 2'h0);
      mc.req <= 1'b1;
      @(posedge i_clk);
      mc.req <= 1'b0;
      watch(12);
      chk(32'(n_k[EXC_MCHECK]), 32'h0000_0000);
      chk(32'(n_k[EXC_RESET] > 0), 32'h0000_0001);
      rdc(OFS_MACHINE_STATE, 32'h0000_1000);
      for (r = 0; r < 6; r++) begin
         hw_reset(ROWS[r][5]);
         apb(1'b1, OFS_DEBUG_ENABLE, {30'h0000_0000, ROWS[r][2], ROWS[r][3]});
         apb(1'b1, OFS_MACHINE_STATE, {19'h0_0000, ROWS[r][4], 12'h000});
         mchk(1'b0, 1'b1, 1'b0);
         watch(6);
         chk(32'(n_stop), 32'(ROWS[r][1:0] == 2'h0));
         chk(32'(n_k[EXC_MCHECK]), 32'(ROWS[r][1:0] == 2'h1));
         chk(32'(n_dbg), 32'(ROWS[r][1:0] == 2'h2));
         if (r == 0) begin
            chk(32'(stop), 32'h0000_0001);
            pulse(1'b1, 2'h0);
            mchk(1'b0, 1'b1, 1'b0);
            watch(30);
            chk(32'(n_k[EXC_NMI] + n_k[EXC_MCHECK]), 32'h0000_0000);
            chk(32'(n_k[EXC_RESET]), 32'h0000_0001);
            chk(32'(stop), 32'h0000_0000);
         end
      end
      complete_run();
   end
endmodule : tb
bind rnm_exception_unit rnm_exception_checker u_rnm_exception_checker (
   .i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_power_on_reset_in_n(i_power_on_reset_in_n),
   .i_hard_reset_in_n(i_hard_reset_in_n),
   .i_soft_reset_in_n(i_soft_reset_in_n),
   .i_internal_reset_req(i_internal_reset_req),
   .i_reset_cfg_prefix(i_reset_cfg_prefix), .i_mcheck(i_mcheck),
   .o_entry(o_entry), .o_checkstop(o_checkstop),
   .o_checkstop_ind(o_checkstop_ind), .o_debug_entry(o_debug_entry),
   .o_fp_precise(o_fp_precise));
